// ### rtl/hiop_defines.vh
// Purpose: shared constants of the host i/o port
// Assumes: included by bare name from every design file
// Notes: register offsets are byte addresses on the apb slave; the base offset is a host i/o address
`ifndef HIOP_DEFINES_VH
`define HIOP_DEFINES_VH

`define HIOP_BASE_OFFSET 10'h300
`define HIOP_BASE_STEP 10'h010

`define HIOP_REG_CTRL 8'h00
`define HIOP_REG_STATUS 8'h04
`define HIOP_REG_MASK 8'h08
`define HIOP_REG_STRAP 8'h0c
`define HIOP_REG_INDEX 8'h10

`define HIOP_CTRL_STB_INV 0
`define HIOP_CTRL_IRQ_INV 1
`define HIOP_CTRL_RESET 2'h0

`define HIOP_EV_CORE 0
`define HIOP_EV_WAIT 1
`define HIOP_EV_RSVD 2
`define HIOP_EV_DONE 3
`define HIOP_EV_W 4
`define HIOP_MASK_RESET 4'h0

`define HIOP_W_BYTE 2'h0
`define HIOP_W_WORD 2'h1
`define HIOP_W_DWORD 2'h2

`define HIOP_ST_IDLE 2'h0
`define HIOP_ST_MEM 2'h1
`define HIOP_ST_HOLD 2'h2

`endif

// ### rtl/hiop_regs.v
// Purpose: apb register slave with sticky interrupt status and mask
// Assumes: zero wait state apb, one clock
// Notes: status bits clear on write of one; a same-cycle event wins
`timescale 1ns/1ns
`default_nettype none
`include "hiop_defines.vh"
module hiop_regs (
    input wire clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire [`HIOP_EV_W-1:0] event_in,
    input wire [7:0] strap_view_in,
    input wire [7:0] index_view_in,
    output wire [1:0] ctrl_out,
    output wire irq_level_out
);
    reg [1:0] ctrl_r;
    reg [`HIOP_EV_W-1:0] status_r;
    reg [`HIOP_EV_W-1:0] mask_r;
    wire access = psel_in & penable_in;
    wire hit = (paddr_in == `HIOP_REG_CTRL) | (paddr_in == `HIOP_REG_STATUS) |
               (paddr_in == `HIOP_REG_MASK) | (paddr_in == `HIOP_REG_STRAP) |
               (paddr_in == `HIOP_REG_INDEX);
    wire wr = access & pwrite_in;
    wire [`HIOP_EV_W-1:0] clr = (wr && paddr_in == `HIOP_REG_STATUS) ?
                                pwdata_in[`HIOP_EV_W-1:0] : {`HIOP_EV_W{1'b0}};

    assign pready_out = 1'b1;
    assign pslverr_out = access & ~hit;
    assign ctrl_out = ctrl_r;
    assign irq_level_out = |(status_r & mask_r);

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= `HIOP_CTRL_RESET;
            mask_r <= `HIOP_MASK_RESET;
            status_r <= {`HIOP_EV_W{1'b0}};
        end else begin
            if (wr && paddr_in == `HIOP_REG_CTRL) begin
                ctrl_r <= pwdata_in[1:0];
            end
            if (wr && paddr_in == `HIOP_REG_MASK) begin
                mask_r <= pwdata_in[`HIOP_EV_W-1:0];
            end
            // set after clear so an event in the clearing cycle survives
            status_r <= (status_r & ~clr) | event_in;
        end
    end

    always @* begin
        prdata_out = 32'h0000_0000;
        case (paddr_in)
            `HIOP_REG_CTRL: prdata_out = {30'h0000_0000, ctrl_r};
            `HIOP_REG_STATUS: prdata_out = {28'h000_0000, status_r};
            `HIOP_REG_MASK: prdata_out = {28'h000_0000, mask_r};
            `HIOP_REG_STRAP: prdata_out = {24'h00_0000, strap_view_in};
            `HIOP_REG_INDEX: prdata_out = {24'h00_0000, index_view_in};
            default: prdata_out = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// ### rtl/hiop_port.v
// Purpose: host i/o port: chip select, address/data ports, wait, width indicators
// Assumes: all host pins synchronous to clk_in; internal memory answers with mem_ack_in
// Notes: straps are caught in the first cycle after reset release
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "hiop_defines.vh"
module hiop_port #(
    parameter INDEX_W = 8
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire hw_reset_in,
    input wire [2:0] strap_base_in,
    input wire strap_irq_pol_in,
    input wire strap_rom_data_in,
    input wire strap_wake_in,
    input wire [5:0] upper_addr_lines_in,
    input wire bus_select_qualifier_in,
    input wire port_select_in,
    input wire host_read_strobe_in,
    input wire host_write_strobe_in,
    input wire [15:0] data_bus_low_in,
    output reg [15:0] data_bus_low_out,
    output wire data_bus_low_oe_out,
    input wire [15:0] data_bus_high_in,
    output reg [15:0] data_bus_high_out,
    output wire data_bus_high_oe_out,
    output wire command_wait_out,
    output wire word_access_ind_n_out,
    output wire dword_access_ind_n_out,
    output wire dword_mode_out,
    output reg irq_out,
    input wire core_irq_in,
    output reg mem_req_out,
    output reg mem_we_out,
    output reg [INDEX_W-1:0] mem_index_out,
    output reg [1:0] mem_width_out,
    output reg [31:0] mem_wdata_out,
    input wire mem_ack_in,
    input wire [31:0] mem_rdata_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out
);
    // reset is async; the hardware reset pin joins the system reset
    wire rst_n = rst_n_in & ~hw_reset_in;

    // the reserved strap pair falls back to word width; status bit 2 tells software
    function [1:0] width_of;
        input rom_data;
        input wake;
        begin
            case ({rom_data, wake})
                2'b00: width_of = `HIOP_W_WORD;
                2'b10: width_of = `HIOP_W_DWORD;
                2'b01: width_of = `HIOP_W_BYTE;
                default: width_of = `HIOP_W_WORD;
            endcase
        end
    endfunction

    // a9 and a8 high with a7 low keeps the port inside the 300h..37fh window
    function hit_of;
        input [5:0] a;
        input qual;
        input [2:0] base;
        begin
            hit_of = a[5] & a[4] & ~a[3] & ~qual & (a[2:0] == base);
        end
    endfunction

    reg strap_done_r;
    reg [2:0] base_r;
    reg irq_pol_r;
    reg [1:0] width_r;
    reg rsvd_r;
    reg dword_r;

    // straps are read once: the shared pins turn into outputs, a later sample is junk
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_r <= 1'b0;
            base_r <= 3'h0;
            irq_pol_r <= 1'b0;
            width_r <= `HIOP_W_WORD;
            rsvd_r <= 1'b0;
            dword_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            base_r <= strap_base_in;
            irq_pol_r <= strap_irq_pol_in;
            width_r <= width_of(strap_rom_data_in, strap_wake_in);
            rsvd_r <= strap_rom_data_in & strap_wake_in;
            dword_r <= strap_rom_data_in & ~strap_wake_in;
        end
    end

    // full decoded base for software view; the pin decode compares bits 6..4
    // the step stays a constant so a wider strap only touches the header
    wire [9:0] io_base = `HIOP_BASE_OFFSET + {7'h00, base_r} * `HIOP_BASE_STEP;

    wire [1:0] ctrl;
    wire irq_level;
    // flipping the polarity while selected fakes a command edge; change it when idle
    wire stb_inv = ctrl[`HIOP_CTRL_STB_INV];
    wire rd_act = stb_inv ? host_read_strobe_in : ~host_read_strobe_in;
    wire wr_act = stb_inv ? host_write_strobe_in : ~host_write_strobe_in;
    wire sel = strap_done_r &
               hit_of(upper_addr_lines_in, bus_select_qualifier_in, base_r);
    wire act = sel & (rd_act | wr_act);

    // edge, not level: a strobe held for many cycles is still one command
    reg act_prev_r;
    wire new_cmd = act & ~act_prev_r;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg cur_rd_r;
    reg cur_data_r;
    reg pend_r;
    reg pend_wr_r;
    reg pend_data_r;
    reg [31:0] pend_wdata_r;
    reg [INDEX_W-1:0] index_r;
    reg rd_ready_r;
    reg [3:0] events;

    // the upper lane carries data only in dword mode; elsewhere those pins do other jobs
    wire [31:0] host_wdata = {dword_r ? data_bus_high_in : 16'h0000, data_bus_low_in};
    wire busy = (state_r == `HIOP_ST_MEM);
    wire done = busy & mem_ack_in;

    // a command is served now if idle, or queued if the memory is still busy
    wire serve_new = new_cmd & ~busy & ~pend_r;
    // only one command can wait; a third is dropped, so the host must obey the wait
    wire queue_new = new_cmd & (busy | pend_r) & ~pend_r;
    wire serve_pend = pend_r & (~busy | done);
    // fields of the command being started; a queued one goes first
    wire cmd_wr = serve_pend ? pend_wr_r : wr_act;
    wire cmd_data = serve_pend ? pend_data_r : port_select_in;
    wire [31:0] cmd_wdata = serve_pend ? pend_wdata_r : host_wdata;

    // hold keeps a finished command from starting again while its strobe stays active
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `HIOP_ST_IDLE: begin
                if ((serve_new & port_select_in) | (serve_pend & pend_data_r)) begin
                    state_nxt = `HIOP_ST_MEM;
                end
            end
            `HIOP_ST_MEM: begin
                if (done) begin
                    state_nxt = (pend_r & pend_data_r) ? `HIOP_ST_MEM : `HIOP_ST_HOLD;
                end
            end
            `HIOP_ST_HOLD: begin
                // a new data command starts from here too; a queued one goes on from mem at done
                if ((serve_new & port_select_in) | (serve_pend & pend_data_r)) begin
                    state_nxt = `HIOP_ST_MEM;
                end else if (!act) begin
                    state_nxt = `HIOP_ST_IDLE;
                end
            end
            default: state_nxt = `HIOP_ST_IDLE;
        endcase
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `HIOP_ST_IDLE;
            act_prev_r <= 1'b0;
            cur_rd_r <= 1'b0;
            cur_data_r <= 1'b0;
            pend_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_data_r <= 1'b0;
            pend_wdata_r <= 32'h0000_0000;
            index_r <= {INDEX_W{1'b0}};
            rd_ready_r <= 1'b0;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_index_out <= {INDEX_W{1'b0}};
            mem_width_out <= `HIOP_W_WORD;
            mem_wdata_out <= 32'h0000_0000;
            data_bus_low_out <= 16'h0000;
            data_bus_high_out <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            act_prev_r <= act;
            if (done) begin
                mem_req_out <= 1'b0;
                if (!mem_we_out) begin
                    // a byte read clears the upper lane so the host sees a clean byte
                    data_bus_low_out <= (width_r == `HIOP_W_BYTE) ?
                                        {8'h00, mem_rdata_in[7:0]} : mem_rdata_in[15:0];
                    data_bus_high_out <= dword_r ? mem_rdata_in[31:16] : 16'h0000;
                    rd_ready_r <= 1'b1;
                end
            end
            if (queue_new) begin
                pend_r <= 1'b1;
                pend_wr_r <= wr_act;
                pend_data_r <= port_select_in;
                pend_wdata_r <= host_wdata;
            end else if (serve_pend) begin
                pend_r <= 1'b0;
            end
            if (serve_new | serve_pend) begin
                cur_rd_r <= ~cmd_wr;
                cur_data_r <= cmd_data;
                rd_ready_r <= 1'b0;
                if (cmd_data) begin
                    mem_req_out <= 1'b1;
                    mem_we_out <= cmd_wr;
                    mem_index_out <= index_r;
                    mem_width_out <= width_r;
                    // a byte write clears the upper bits so stale host data never lands
                    mem_wdata_out <= (width_r == `HIOP_W_BYTE) ?
                                     {24'h00_0000, cmd_wdata[7:0]} : cmd_wdata;
                end else if (cmd_wr) begin
                    index_r <= cmd_wdata[INDEX_W-1:0];
                end else begin
                    data_bus_low_out <= {{(16-INDEX_W){1'b0}}, index_r};
                    data_bus_high_out <= 16'h0000;
                    rd_ready_r <= 1'b1;
                end
            end
        end
    end

    // a read must also wait until its data has come back from memory
    wire rd_waiting = act & rd_act & cur_rd_r & ~rd_ready_r;
    assign command_wait_out = ~(pend_r | rd_waiting);

    // drive only under a selected read strobe so host and port never fight the bus
    wire drive = sel & rd_act & cur_rd_r & rd_ready_r & ~pend_r;
    assign data_bus_low_oe_out = drive;
    assign data_bus_high_oe_out = drive & dword_r & cur_data_r;
    assign dword_mode_out = dword_r;

    // indicators follow the strobe, not the memory, so they settle before the host samples
    wire data_cyc = act & port_select_in;
    assign word_access_ind_n_out = ~(data_cyc & (width_r != `HIOP_W_BYTE));
    assign dword_access_ind_n_out = ~(data_cyc & dword_r &
                                      (width_r == `HIOP_W_DWORD));

    reg core_prev_r;
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            core_prev_r <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            core_prev_r <= core_irq_in;
            // strap picks the idle level; configuration flips it again
            irq_out <= irq_level ^ irq_pol_r ^ ctrl[`HIOP_CTRL_IRQ_INV];
        end
    end

    // events are one-cycle pulses; the status register makes them sticky
    always @* begin
        events = 4'h0;
        events[`HIOP_EV_CORE] = core_irq_in & ~core_prev_r;
        events[`HIOP_EV_WAIT] = queue_new;
        events[`HIOP_EV_RSVD] = new_cmd & port_select_in & rsvd_r;
        events[`HIOP_EV_DONE] = done;
    end

    hiop_regs u_regs (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .event_in(events),
        .strap_view_in({dword_r, rsvd_r, width_r, irq_pol_r, base_r}),
        .index_view_in(io_base[9:2]),
        .ctrl_out(ctrl),
        .irq_level_out(irq_level)
    );
endmodule
`default_nettype wire

// ### test/hiop_port_asserts.sv
// Purpose: pin level checks of the host i/o port
// Assumes: bound to hiop_port, strobes idle between commands
// Notes: strobe polarity lives in a register, so selection is judged by address only
`timescale 1ns/1ns
`default_nettype none
module hiop_port_asserts #(
    parameter INDEX_W = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic hw_reset_in,
    input wire logic [5:0] upper_addr_lines_in,
    input wire logic bus_select_qualifier_in,
    input wire logic port_select_in,
    input wire logic [15:0] data_bus_low_out,
    input wire logic data_bus_low_oe_out,
    input wire logic data_bus_high_oe_out,
    input wire logic command_wait_out,
    input wire logic word_access_ind_n_out,
    input wire logic dword_access_ind_n_out,
    input wire logic dword_mode_out,
    input wire logic mem_req_out,
    input wire logic mem_we_out,
    input wire logic [INDEX_W-1:0] mem_index_out,
    input wire logic [1:0] mem_width_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_rdata_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || hw_reset_in);
    // counts edges since release, straps are only final after the first
    logic [1:0] up_r;
    always @(posedge clk_in or negedge rst_n_in or posedge hw_reset_in) begin
        if (!rst_n_in || hw_reset_in) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    sequence s_read_ack;
        mem_req_out && !mem_we_out && mem_ack_in;
    endsequence
    sequence s_sel;
        upper_addr_lines_in[5:3] == 3'b110 && !bus_select_qualifier_in;
    endsequence
    a_oe_needs_sel: assert property (data_bus_low_oe_out |-> s_sel)
        else $error("data bus driven while not selected");
    a_high_oe_mode: assert property (data_bus_high_oe_out |-> dword_mode_out)
        else $error("high data bus driven outside dword mode");
    a_dword_ind: assert property (!dword_access_ind_n_out |->
        dword_mode_out && !word_access_ind_n_out)
        else $error("dword indicator without dword mode");
    a_word_ind: assert property (!word_access_ind_n_out |-> port_select_in ##0 s_sel)
        else $error("word indicator outside a data port access");
    a_req_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out &&
        $stable(mem_index_out) && $stable(mem_we_out))
        else $error("memory request changed before acknowledge");
    a_read_wait: assert property (mem_req_out && !mem_we_out |-> !command_wait_out)
        else $error("wait released with read outstanding");
    a_read_data: assert property (s_read_ack ##0 mem_width_out == 2'h1 |=>
        data_bus_low_out == $past(mem_rdata_in[15:0]))
        else $error("read data not presented after acknowledge");
    a_width_mode: assert property (mem_req_out |->
        (mem_width_out == 2'h2) == dword_mode_out)
        else $error("memory width disagrees with mode");
    a_straps_held: assert property (up_r == 2'h3 |-> $stable(dword_mode_out))
        else $error("dword mode changed during operation");
    a_hw_reset: assert property (disable iff (!rst_n_in) hw_reset_in |->
        !mem_req_out && command_wait_out && !data_bus_low_oe_out && word_access_ind_n_out)
        else $error("outputs active during hardware reset");
endmodule
bind hiop_port hiop_port_asserts #(.INDEX_W(INDEX_W)) i_hiop_port_asserts (.*);
`default_nettype wire

// ### test/hiop_mem_model.sv
// Purpose: internal memory behind the port, acknowledge after a set latency
// Assumes: request held until acknowledge, dropped the cycle after
// Notes: read data toggles outside the acknowledge so a late sample shows up
`timescale 1ns/1ns
`default_nettype none
module hiop_mem_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [7:0] index_in,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] lat_in,
    output logic ack_out,
    output logic [31:0] rdata_out
);
    logic [31:0] mem_r [0:255];
    logic [3:0] cnt_r;
    logic gap_r;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            cnt_r <= 4'h0;
            gap_r <= 1'b0;
            rdata_out <= 32'h0;
        end else begin
            ack_out <= 1'b0;
            gap_r <= ack_out;
            rdata_out <= ~rdata_out;
            if (req_in && !ack_out && !gap_r) begin
                if (cnt_r >= lat_in) begin
                    ack_out <= 1'b1;
                    cnt_r <= 4'h0;
                    if (we_in) mem_r[index_in] <= wdata_in;
                    else rdata_out <= mem_r[index_in];
                end else cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/hiop_port_tb.sv
// Purpose: self-checking bench of the host i/o port over eight strap settings, each strap pin seen at both levels
// Assumes: host cycles spaced by an idle strobe cycle
// Notes: the bench keeps its own memory image for expected read data
`timescale 1ns/1ns
`default_nettype none
module hiop_port_tb;
    logic clk_in, rst_n_in = 0, hw_reset_in = 0, strap_irq_pol_in = 0, strap_rom_data_in = 0;
    logic strap_wake_in = 0, bus_select_qualifier_in = 0, port_select_in = 0, core_irq_in = 0;
    logic host_read_strobe_in = 1, host_write_strobe_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, inv = 0, r, wk, p, dw, e, oe_s, wi_s, di_s;
    logic [2:0] strap_base_in = 0, b;
    logic [5:0] upper_addr_lines_in = 0, a;
    logic [7:0] paddr_in = 0, idx;
    logic [31:0] pwdata_in = 0, hd = 0, q, d, mask;
    logic [3:0] lat = 4'h1;
    logic [1:0] wd;
    wire [15:0] data_bus_low_out, data_bus_high_out, data_bus_low_in, data_bus_high_in;
    wire data_bus_low_oe_out, data_bus_high_oe_out, command_wait_out, word_access_ind_n_out;
    wire dword_access_ind_n_out, dword_mode_out, irq_out, mem_req_out, mem_we_out, mem_ack_in;
    wire pready_out, pslverr_out;
    wire [7:0] mem_index_out;
    wire [1:0] mem_width_out;
    wire [31:0] mem_wdata_out, mem_rdata_in, prdata_out;
    int bad_count = 0, check_count = 0, wn, i;
    int ref_mem[int];
    // the pin carries the device value whenever it drives, else the host value
    assign data_bus_low_in = data_bus_low_oe_out ? data_bus_low_out : hd[15:0];
    assign data_bus_high_in = data_bus_high_oe_out ? data_bus_high_out : hd[31:16];
    hiop_port i_hiop_port (.*);
    hiop_mem_model i_hiop_mem_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(mem_req_out),
        .we_in(mem_we_out), .index_in(mem_index_out), .wdata_in(mem_wdata_out), .lat_in(lat),
        .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic tmo;
        bad_count++;
        $display("CHECK FAILED wait bound expected answer seen none");
        complete_run();
    endtask
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] wdat);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= ad;
        pwdata_in <= wdat;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        for (n = 0; n < 20 && pready_out !== 1'b1; n++) @(posedge clk_in);
        if (n == 20) tmo();
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic hcyc(logic w, logic ps, logic [5:0] ad, logic [31:0] wdat);
        int n;
        @(posedge clk_in);
        upper_addr_lines_in <= ad;
        port_select_in <= ps;
        hd <= wdat;
        if (w) host_write_strobe_in <= inv;
        else host_read_strobe_in <= inv;
        repeat (2) @(posedge clk_in);
        for (n = 0; n < 60 && command_wait_out !== 1'b1; n++) @(posedge clk_in);
        if (n == 60) tmo();
        wn = n;
        q = {data_bus_high_out, data_bus_low_out};
        oe_s = data_bus_low_oe_out;
        wi_s = word_access_ind_n_out;
        di_s = dword_access_ind_n_out;
        host_write_strobe_in <= ~inv;
        host_read_strobe_in <= ~inv;
        upper_addr_lines_in <= 6'h00;
    endtask
    // straps are moved right after they were caught, the port must ignore that
    task automatic setup(logic [2:0] sb, logic sr, logic sw, logic sp);
        @(posedge clk_in);
        {strap_base_in, strap_rom_data_in, strap_wake_in, strap_irq_pol_in} <= {sb, sr, sw, sp};
        hw_reset_in <= 1'b1;
        inv = 1'b0;
        @(posedge clk_in);
        hw_reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        {strap_base_in, strap_rom_data_in, strap_wake_in, strap_irq_pol_in} <= 6'($urandom);
        repeat (2) @(posedge clk_in);
    endtask
    initial begin
        void'($urandom(57));
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        for (i = 0; i < 8; i++) begin
            {p, wk, r} = 3'(i);
            b = 3'(i);
            setup(b, r, wk, p);
            dw = r & !wk;
            wd = dw ? 2'h2 : (!r & wk) ? 2'h0 : 2'h1;
            mask = dw ? 32'hffffffff : (wd == 2'h1) ? 32'h0000ffff : 32'h000000ff;
            a = {3'b110, b};
            chk("dword mode", dw, dword_mode_out);
            chk("irq idle", p, irq_out);
            apb(1'b0, 8'h10, 32'h0);
            chk("base index", (32'h300 + b * 32'h10) >> 2, q);
            idx = 8'($urandom);
            d = $urandom;
            hcyc(1'b1, 1'b0, a, idx);
            hcyc(1'b0, 1'b0, a, 32'h0);
            chk("index port", idx, q[7:0]);
            ref_mem[idx] = d;
            hcyc(1'b1, 1'b1, a, d);
            hcyc(1'b0, 1'b1, a, 32'h0);
            chk("read data", ref_mem[idx] & mask, q & mask);
            chk("word ind", wd == 2'h0, wi_s);
            chk("dword ind", !dw, di_s);
            apb(1'b0, 8'h04, 32'h0);
            chk("reserved width flag", r & wk, q[2]);
            hcyc(1'b0, 1'b1, {3'b110, ~b}, 32'h0);
            chk("unselected oe", 1'b0, oe_s);
            $display("strap set %0d test done", i);
        end
        setup(3'h2, 1'b0, 1'b0, 1'b0);
        a = 6'h32;
        apb(1'b1, 8'h08, 32'h1);
        core_irq_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("irq raised", 1'b1, irq_out);
        apb(1'b1, 8'h08, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("irq masked", 1'b0, irq_out);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h04, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", 1'b0, irq_out);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 1'b1, e);
        chk("unmapped data", 32'h0, q);
        $display("interrupt test done");
        apb(1'b1, 8'h00, 32'h3);
        inv = 1'b1;
        host_read_strobe_in <= 1'b0;
        host_write_strobe_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk("irq inverted", 1'b1, irq_out);
        lat = 4'ha;
        idx = 8'($urandom);
        hcyc(1'b1, 1'b0, a, idx);
        hcyc(1'b1, 1'b1, a, $urandom);
        d = $urandom;
        ref_mem[idx] = d;
        hcyc(1'b1, 1'b1, a, d);
        chk("queued wait", 1'b1, wn > 0);
        hcyc(1'b1, 1'b0, a, idx);
        hcyc(1'b0, 1'b1, a, 32'h0);
        chk("inverted strobe read", ref_mem[idx] & 32'hffff, q & 32'hffff);
        $display("strobe and wait test done");
        complete_run();
    end
endmodule
`default_nettype wire
